/* rtl/hsi_pkg.sv */
// hsi_pkg: constants and carrier types for the second data-link
// interrupt enable / signalling status block.
// assumes an 8-bit host register port local to one framer channel.
package hsi_pkg;

   // register offsets within the channel page
   localparam logic [7:0] HDLC_STATUS_OFS   = 8'h16;
   localparam logic [7:0] DL2_IRQ_EN_OFS    = 8'h17;
   localparam logic [7:0] SIG_STATUS_OFS    = 8'h18;
   localparam logic [7:0] SIG_IRQ_EN_OFS    = 8'h19;
   localparam logic [7:0] SIG_CONFIG_OFS    = 8'h1A;

   // reset values
   localparam logic [7:0] DL2_IRQ_EN_RST    = 8'h00;
   localparam logic [7:0] SIG_IRQ_EN_RST    = 8'h00;
   localparam logic [7:0] STATUS_RST        = 8'h00;
   localparam logic [7:0] SIG_CONFIG_RST    = 8'h00;

   // implemented bits of each register
   localparam logic [7:0] HDLC_BITS_MASK    = 8'h7F;
   localparam logic [7:0] SIG_BITS_MASK     = 8'h3F;
   localparam logic [7:0] CONFIG_BITS_MASK  = 8'h03;

   // hdlc status / enable bit positions
   localparam int TX_BEGIN_BIT   = 6;
   localparam int RX_BEGIN_BIT   = 5;
   localparam int TX_DONE_BIT    = 4;
   localparam int RX_DONE_BIT    = 3;
   localparam int FCS_FAIL_BIT   = 2;
   localparam int RX_ABORT_BIT   = 1;
   localparam int RX_IDLE_BIT    = 0;

   // signalling status / enable bit positions
   localparam int SIG_TX_BEGIN_BIT  = 5;
   localparam int SIG_RX_BEGIN_BIT  = 4;
   localparam int SIG_TX_DONE_BIT   = 3;
   localparam int SIG_RX_DONE_BIT   = 2;
   localparam int SIG_CRC_FAIL_BIT  = 1;
   localparam int SIG_OVERSIZE_BIT  = 0;

   // configuration bit positions
   localparam int CFG_THRESH_SEL_BIT = 0;
   localparam int CFG_SIG_MODE_BIT   = 1;

   // thresholds
   localparam logic [6:0] CRC_THRESH_LOW    = 7'h20;
   localparam logic [6:0] CRC_THRESH_HIGH   = 7'h40;
   localparam logic [8:0] MAX_MSG_BYTES     = 9'h114;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic       wrStrobe;
      logic       rdStrobe;
   } hsi_bus_req_t;

   typedef struct packed {
      logic txBegin;
      logic rxBegin;
      logic txDone;
      logic rxDone;
      logic fcsFail;
      logic rxAbort;
      logic rxIdle;
   } hsi_hdlc_evt_t;

   typedef struct packed {
      logic txBegin;
      logic rxBegin;
      logic txDone;
      logic rxDone;
      logic frameDone;
      logic crcBad;
      logic rxByte;
   } hsi_sig_evt_t;

endpackage

/* rtl/hsi_regs.sv */
// hsi_regs: enable, status and config registers of the second data-link
// controller with one level interrupt output.
// assumes event pulses come from hdlc logic on the same clock, one cycle
// each, and a host port that never waits.
//
// Notes on behaviour
// RULE1: enable bit 6 lets a transmit-message-start event interrupt.
// RULE2: enable bit 5 lets a receive-message-start event interrupt.
// RULE3: enable bit 4 lets a transmit-message-done event interrupt.
// RULE4: enable bit 3 lets a receive-message-complete event interrupt.
// RULE5: enable bit 2 lets a frame check sequence error interrupt.
// RULE6: enable bit 1 lets an abort (seven ones in a row) interrupt.
// RULE7: enable bit 0 lets a received idle flag octet interrupt.
// RULE8: enable bits are read/write, 1 permits, and reset to 0.
// RULE9: signalling bit 1 sets when 32 or 64 consecutive bad-crc frames pass.
// RULE10: signalling bit 0 sets when a received message exceeds 276 bytes.
// RULE11: status flags show events since the last read and clear on read.
// RULE12: signalling bits 5..2 flag tx/rx start and end in signalling mode.
// RULE13: a separate signalling enable bit, reset 0, gates the crc failure.
// RULE14: the interrupt is high while any enabled status flag is set.
`timescale 1ns/1ps

module hsi_regs #(
   parameter int CRC_CNT_W  = 7,
   parameter int BYTE_CNT_W = 9
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 resetn,
   // host register port
   input  wire hsi_pkg::hsi_bus_req_t busReq,
   output logic [7:0]                rdData,
   // event pulses from the hdlc controller
   input  wire hsi_pkg::hsi_hdlc_evt_t hdlcEvt,
   input  wire hsi_pkg::hsi_sig_evt_t  sigEvt,
   // interrupt
   output logic                      irq
);

   logic [7:0]            hdlcIrqEn_r;
   logic [7:0]            sigIrqEn_r;
   logic [7:0]            sigConfig_r;
   logic [7:0]            hdlcStat_r;
   logic [7:0]            sigStat_r;
   logic [7:0]            rdData_r;
   logic [CRC_CNT_W-1:0]  crcCnt_r;
   logic [BYTE_CNT_W-1:0] byteCnt_r;

   logic [7:0]            hdlcSet;
   logic [7:0]            sigSet;
   logic [7:0]            hdlcClr;
   logic [7:0]            sigClr;
   logic                  crcTrip;
   logic                  oversizeTrip;
   logic                  sigMode;
   logic [CRC_CNT_W-1:0]  crcLimit;

   // set beats clear so an event in the clearing cycle survives
   function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                            input logic [7:0] set,
                                            input logic [7:0] clr,
                                            input logic [7:0] keep);
      flag_next = ((cur & ~clr) | set) & keep;
   endfunction

   function automatic logic hit(input hsi_pkg::hsi_bus_req_t r,
                                input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   assign sigMode  = sigConfig_r[hsi_pkg::CFG_SIG_MODE_BIT];
   assign crcLimit = sigConfig_r[hsi_pkg::CFG_THRESH_SEL_BIT]
                   ? CRC_CNT_W'(hsi_pkg::CRC_THRESH_HIGH)
                   : CRC_CNT_W'(hsi_pkg::CRC_THRESH_LOW);

   // enable registers
   always_ff @(posedge clock) begin
      if (!resetn) begin
         hdlcIrqEn_r <= hsi_pkg::DL2_IRQ_EN_RST;               // [RULE8]
         sigIrqEn_r  <= hsi_pkg::SIG_IRQ_EN_RST;               // [RULE13]
      end else if (busReq.wrStrobe) begin
         if (hit(busReq, hsi_pkg::DL2_IRQ_EN_OFS)) begin
            hdlcIrqEn_r <= busReq.wrData & hsi_pkg::HDLC_BITS_MASK; // [RULE8]
         end
         if (hit(busReq, hsi_pkg::SIG_IRQ_EN_OFS)) begin
            sigIrqEn_r <= busReq.wrData & hsi_pkg::SIG_BITS_MASK;
         end
      end
   end

   // configuration: threshold select and signalling mode
   always_ff @(posedge clock) begin
      if (!resetn) begin
         sigConfig_r <= hsi_pkg::SIG_CONFIG_RST;
      end else if (busReq.wrStrobe
                   && hit(busReq, hsi_pkg::SIG_CONFIG_OFS)) begin
         sigConfig_r <= busReq.wrData & hsi_pkg::CONFIG_BITS_MASK;
      end
   end

   // consecutive bad-crc frame counter; a good frame restarts it
   assign crcTrip = sigEvt.frameDone && sigEvt.crcBad
                  && (crcCnt_r == crcLimit - CRC_CNT_W'(1));   // [RULE9]

   always_ff @(posedge clock) begin
      if (!resetn) begin
         crcCnt_r <= '0;
      end else if (sigEvt.frameDone) begin
         if (!sigEvt.crcBad || crcTrip) begin
            crcCnt_r <= '0;                                    // [RULE9]
         end else begin
            crcCnt_r <= crcCnt_r + CRC_CNT_W'(1);
         end
      end
   end

   // received byte counter, saturates once past the limit
   assign oversizeTrip = sigEvt.rxByte && !sigEvt.rxBegin
                       && (byteCnt_r == BYTE_CNT_W'(hsi_pkg::MAX_MSG_BYTES));

   always_ff @(posedge clock) begin
      if (!resetn) begin
         byteCnt_r <= '0;
      end else if (sigEvt.rxBegin) begin
         byteCnt_r <= sigEvt.rxByte ? BYTE_CNT_W'(1) : '0;
      end else if (sigEvt.rxByte
                   && byteCnt_r <= BYTE_CNT_W'(hsi_pkg::MAX_MSG_BYTES)) begin
         byteCnt_r <= byteCnt_r + BYTE_CNT_W'(1);              // [RULE10]
      end
   end

   // event to status bit mapping
   always_comb begin
      hdlcSet = '0;
      hdlcSet[hsi_pkg::TX_BEGIN_BIT] = hdlcEvt.txBegin;        // [RULE1]
      hdlcSet[hsi_pkg::RX_BEGIN_BIT] = hdlcEvt.rxBegin;        // [RULE2]
      hdlcSet[hsi_pkg::TX_DONE_BIT]  = hdlcEvt.txDone;         // [RULE3]
      hdlcSet[hsi_pkg::RX_DONE_BIT]  = hdlcEvt.rxDone;         // [RULE4]
      hdlcSet[hsi_pkg::FCS_FAIL_BIT] = hdlcEvt.fcsFail;        // [RULE5]
      hdlcSet[hsi_pkg::RX_ABORT_BIT] = hdlcEvt.rxAbort;        // [RULE6]
      hdlcSet[hsi_pkg::RX_IDLE_BIT]  = hdlcEvt.rxIdle;         // [RULE7]
   end

   always_comb begin
      sigSet = '0;
      sigSet[hsi_pkg::SIG_TX_BEGIN_BIT] = sigMode && sigEvt.txBegin; // [RULE12]
      sigSet[hsi_pkg::SIG_RX_BEGIN_BIT] = sigMode && sigEvt.rxBegin; // [RULE12]
      sigSet[hsi_pkg::SIG_TX_DONE_BIT]  = sigMode && sigEvt.txDone;  // [RULE12]
      sigSet[hsi_pkg::SIG_RX_DONE_BIT]  = sigMode && sigEvt.rxDone;  // [RULE12]
      sigSet[hsi_pkg::SIG_CRC_FAIL_BIT] = crcTrip;                   // [RULE9]
      sigSet[hsi_pkg::SIG_OVERSIZE_BIT] = oversizeTrip;              // [RULE10]
   end

   // clear by read of the register, or by writing ones to it
   always_comb begin
      hdlcClr = '0;
      sigClr  = '0;
      if (busReq.rdStrobe && hit(busReq, hsi_pkg::HDLC_STATUS_OFS)) begin
         hdlcClr = 8'hFF;                                      // [RULE11]
      end
      if (busReq.wrStrobe && hit(busReq, hsi_pkg::HDLC_STATUS_OFS)) begin
         hdlcClr = busReq.wrData;
      end
      if (busReq.rdStrobe && hit(busReq, hsi_pkg::SIG_STATUS_OFS)) begin
         sigClr = 8'hFF;                                       // [RULE11]
      end
      if (busReq.wrStrobe && hit(busReq, hsi_pkg::SIG_STATUS_OFS)) begin
         sigClr = busReq.wrData;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         hdlcStat_r <= hsi_pkg::STATUS_RST;
      end else begin
         hdlcStat_r <= flag_next(hdlcStat_r, hdlcSet, hdlcClr,
                                 hsi_pkg::HDLC_BITS_MASK);     // [RULE11]
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         sigStat_r <= hsi_pkg::STATUS_RST;
      end else begin
         sigStat_r <= flag_next(sigStat_r, sigSet, sigClr,
                                hsi_pkg::SIG_BITS_MASK);       // [RULE11]
      end
   end

   // read data one cycle after the strobe; reserved bits read zero
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdData_r <= '0;
      end else if (busReq.rdStrobe) begin
         unique case (busReq.addr)
            hsi_pkg::HDLC_STATUS_OFS: rdData_r <= hdlcStat_r;
            hsi_pkg::DL2_IRQ_EN_OFS:  rdData_r <= hdlcIrqEn_r;  // [RULE8]
            hsi_pkg::SIG_STATUS_OFS:  rdData_r <= sigStat_r;    // [RULE11]
            hsi_pkg::SIG_IRQ_EN_OFS:  rdData_r <= sigIrqEn_r;
            hsi_pkg::SIG_CONFIG_OFS:  rdData_r <= sigConfig_r;
            default:                  rdData_r <= '0;
         endcase
      end else begin
         rdData_r <= '0;
      end
   end

   assign rdData = rdData_r;

   // registered level output, drops one cycle after the last enabled flag clears
   always_ff @(posedge clock) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(hdlcStat_r & hdlcIrqEn_r)                   // [RULE14]
              | |(sigStat_r & sigIrqEn_r);                     // [RULE13]
      end
   end

endmodule // hsi_regs

/* tb/hsi_regs_chk.sv */
// hsi_regs_chk: port-level assertions for the data-link interrupt block.
// assumes it is bound to hsi_regs and sees only that module's ports.
`timescale 1ns/1ps
module hsi_regs_chk (
   // clock and reset
   input wire logic                   clock,
   input wire logic                   resetn,
   // host port
   input wire hsi_pkg::hsi_bus_req_t  busReq,
   input wire logic [7:0]             rdData,
   // events and interrupt
   input wire hsi_pkg::hsi_hdlc_evt_t hdlcEvt,
   input wire hsi_pkg::hsi_sig_evt_t  sigEvt,
   input wire logic                   irq
);
   logic [6:0] enCopy_r;
   logic       rdStat;
   logic       wrEn;
   logic       busIdle;
   assign rdStat = busReq.rdStrobe && busReq.addr == hsi_pkg::HDLC_STATUS_OFS;
   assign wrEn = busReq.wrStrobe && busReq.addr == hsi_pkg::DL2_IRQ_EN_OFS;
   assign busIdle = !busReq.rdStrobe && !busReq.wrStrobe;
   // shadow of the enable register, needed to judge irq
   always_ff @(posedge clock) begin
      if (!resetn) enCopy_r <= 7'h00;
      else if (wrEn) enCopy_r <= busReq.wrData[6:0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   AST_RD_IDLE_ZERO: assert property (
      !$past(busReq.rdStrobe) |-> rdData == 8'h00)
      else $error("read data not zero outside read slot");
   AST_RD_TOP_ZERO: assert property (
      busReq.rdStrobe |=> rdData[7] == 1'b0)
      else $error("reserved bit 7 read as one");
   AST_EN_READBACK: assert property (
      wrEn ##1 (busReq.rdStrobe && busReq.addr == hsi_pkg::DL2_IRQ_EN_OFS)
      |=> rdData == {1'b0, $past(busReq.wrData[6:0], 2)})
      else $error("enable readback differs from write");
   AST_IRQ_ON_EVT: assert property (
      (hdlcEvt & enCopy_r) != 7'h00 && !busReq.wrStrobe |-> ##2 irq)
      else $error("enabled event gave no interrupt");
   AST_IRQ_CAUSE: assert property (
      $rose(irq) |->
      $past(hdlcEvt != 7'h00 || sigEvt != 7'h00 || busReq.wrStrobe, 2))
      else $error("interrupt rose without cause");
   AST_IRQ_HOLD: assert property (
      busIdle ##1 irq |=> irq)
      else $error("interrupt dropped with no clear");
   AST_RD_CLEARS: assert property (
      rdStat && hdlcEvt == 7'h00 ##1 rdStat |=> rdData == 8'h00)
      else $error("status not cleared by read");
   AST_EVT_SHOWS: assert property (
      hdlcEvt != 7'h00 ##1 rdStat
      |=> (rdData[6:0] & $past(hdlcEvt, 2)) == $past(hdlcEvt, 2))
      else $error("event missing from status");
endmodule // hsi_regs_chk

/* tb/test_hdlc2_ss7_interrupt_regs.sv */
// test_hdlc2_ss7_interrupt_regs: self-checking bench for hsi_regs.
// assumes the checker is bound below and the bench drives every input port.
`timescale 1ns/1ps
module test_hdlc2_ss7_interrupt_regs;
   logic                   clock = 1'b0;
   logic                   resetn = 1'b0;
   hsi_pkg::hsi_bus_req_t  busReq = '0;
   logic [7:0]             rdData;
   hsi_pkg::hsi_hdlc_evt_t hdlcEvt = '0;
   hsi_pkg::hsi_sig_evt_t  sigEvt = '0;
   logic                   irq;
   int                     miscompares = 0;
   int                     checks = 0;
   int                     cycles = 0;
   logic [7:0]             d;
   always #12.5 clock = ~clock;
   hsi_regs dut (.clock(clock), .resetn(resetn), .busReq(busReq),
      .rdData(rdData), .hdlcEvt(hdlcEvt), .sigEvt(sigEvt), .irq(irq));
   task chk(string n, logic [7:0] e, logic [7:0] s);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // every bus and event task returns 1 ns after an edge, so calls may follow directly
   task wr(logic [7:0] a, logic [7:0] v);
      busReq <= '{a, v, 1'b1, 1'b0};
      @(posedge clock);
      busReq <= '0;
      #1;
   endtask
   task rd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
      busReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      busReq <= '0;
      #1 chk("rdData", e, rdData & m);
   endtask
   task rs(logic [7:0] e, logic [7:0] m);
      rd(hsi_pkg::SIG_STATUS_OFS, e, m);
   endtask
   task ev(logic [6:0] h, logic [6:0] s);
      hdlcEvt <= h;
      sigEvt <= s;
      @(posedge clock);
      hdlcEvt <= '0;
      sigEvt <= '0;
      #1;
   endtask
   task ci(logic e);
      chk("irq", {7'h00, e}, {7'h00, irq});
   endtask
   task frames(int n, logic bad);
      repeat (n) ev(7'h00, {4'h0, 1'b1, bad, 1'b0});
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      d = 8'($urandom(20));
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      #1;
      for (int a = 8'h14; a < 8'h1C; a++) rd(8'(a), 8'h00, 8'hFF);
      repeat (8) begin
         d = 8'($urandom);
         wr(hsi_pkg::DL2_IRQ_EN_OFS, d);
         rd(hsi_pkg::DL2_IRQ_EN_OFS, d & 8'h7F, 8'hFF);
      end
      for (int i = 0; i < 7; i++) begin
         wr(hsi_pkg::DL2_IRQ_EN_OFS, 8'(1 << i));
         d = 8'($urandom & 32'h7F & ~(32'h1 << i));
         ev(d[6:0], 7'h00);
         repeat (2) @(posedge clock);
         #1 ci(1'b0);
         ev(7'(1 << i), 7'h00);
         rd(hsi_pkg::HDLC_STATUS_OFS, d | 8'(1 << i), 8'hFF);
         ci(1'b1);
         rd(hsi_pkg::HDLC_STATUS_OFS, 8'h00, 8'hFF);
         ci(1'b0);
      end
      wr(hsi_pkg::SIG_IRQ_EN_OFS, 8'hFF);
      rd(hsi_pkg::SIG_IRQ_EN_OFS, 8'h3F, 8'hFF);
      ev(7'h00, 7'h78);
      rs(8'h00, 8'hFF);
      wr(hsi_pkg::SIG_CONFIG_OFS, 8'h02);
      ev(7'h00, 7'h78);
      rs(8'h3C, 8'hFF);
      frames(20, 1'b1);
      frames(1, 1'b0);
      frames(31, 1'b1);
      rs(8'h00, 8'h02);
      frames(1, 1'b1);
      @(posedge clock);
      #1 ci(1'b1);
      rs(8'h02, 8'h02);
      wr(hsi_pkg::SIG_IRQ_EN_OFS, 8'h3D);
      wr(hsi_pkg::SIG_CONFIG_OFS, 8'h03);
      frames(63, 1'b1);
      rs(8'h00, 8'h02);
      frames(1, 1'b1);
      @(posedge clock);
      #1 ci(1'b0);
      rs(8'h02, 8'h02);
      wr(hsi_pkg::SIG_IRQ_EN_OFS, 8'h01);
      ev(7'h00, 7'h21);
      repeat (275) ev(7'h00, 7'h01);
      rs(8'h00, 8'h01);
      ev(7'h00, 7'h01);
      @(posedge clock);
      #1 ci(1'b1);
      rs(8'h01, 8'h01);
      test_done();
   end
endmodule // test_hdlc2_ss7_interrupt_regs

bind hsi_regs hsi_regs_chk chk (.clock(clock), .resetn(resetn),
   .busReq(busReq), .rdData(rdData), .hdlcEvt(hdlcEvt), .sigEvt(sigEvt),
   .irq(irq));
